// [rtl/rsc_consts.svh]
/*
  Constants of the system reset controller: register offsets, field
  positions, reset values and timing counts. Assumes a 125 MHz aclk.
*/
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

`define RSC_CLK_MHZ 125
// Pin low time needed for a reset, and its least cycle count
`define RSC_T_RST_NS 400
`define RSC_RST_CYC ((`RSC_T_RST_NS * `RSC_CLK_MHZ + 999) / 1000)
// Shortest supply dip the undervolt detector acts on
`define RSC_T_BOD_NS 1000
`define RSC_BOD_CYC ((`RSC_T_BOD_NS * `RSC_CLK_MHZ + 999) / 1000)
// Delay counter tick
`define RSC_TICK_NS 1000
`define RSC_TICK_CYC (`RSC_TICK_NS * `RSC_CLK_MHZ / 1000)
// Start-up time-out choices, in microseconds (one tick each)
`define RSC_TOUT_SHORT_US 0
`define RSC_TOUT_MID_US 4100
`define RSC_TOUT_LONG_US 65000
`define RSC_XTAL_START_US 131
`define RSC_TICK_US 1

// Register byte offsets
`define RSC_OFF_CAUSE 8'h00
`define RSC_OFF_IRQ_ST 8'h04
`define RSC_OFF_IRQ_MASK 8'h08
`define RSC_OFF_CTRL 8'h0c
`define RSC_OFF_STATE 8'h10

// Cause and interrupt bit positions
`define RSC_B_POR 0
`define RSC_B_EXT 1
`define RSC_B_BOD 2
`define RSC_B_WDT 3
`define RSC_B_JTAG 4
`define RSC_B_USB 5
// Control fields
`define RSC_B_USB_CPU_EN 0
// State register fields
`define RSC_B_BUSY 0
`define RSC_B_BOD_EN 1
`define RSC_F_SUT_LSB 4
`define RSC_F_CLOCK_SOURCE_FUSES_LSB 8

// Reset values, undervolt-off fuse code and bus response codes
`define RSC_CAUSE_RST 6'h00
`define RSC_MASK_RST 6'h00
`define RSC_UV_OFF 3'h7
`define RSC_RESP_OK 2'h0
`define RSC_RESP_ERR 2'h2

`endif

// [rtl/rsc_pkg.sv]
/*
  Types of the system reset controller. Constants live in rsc_consts.svh.
*/
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_HOLD = 2'b00,
    RSC_COUNT = 2'b01,
    RSC_RUN = 2'b10
  } rsc_dly_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic [7:0] cnt;
    logic q;
  } rsc_qual_s;

  typedef struct packed {
    rsc_dly_e st;
    logic [6:0] div;
    logic [16:0] cnt;
  } rsc_dly_s;

  typedef struct packed {
    logic [5:0] cause;
    logic [5:0] irq_st;
    logic [5:0] irq_mask;
    logic usb_cpu_en;
    logic por_q;
    logic ext_q;
    logic bod_q;
    logic jtag_q;
    logic wdt_pulse;
    logic usb_pulse;
    logic cpu_rst;
    logic fetch;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rsc_top_s;

endpackage

// [rtl/rsc_dly_if.sv]
/*
  Carrier between the reset combiner and the delay counter.
  Same clock on both ends.
*/
`timescale 1ns/10ps
`default_nettype none

interface rsc_dly_if;
  logic hold;
  logic [16:0] ticks;
  logic busy;
  modport ctl (output hold, output ticks, input busy);
  modport cnt (input hold, input ticks, output busy);
endinterface

`default_nettype wire

// [rtl/rsc_qual.sv]
/*
  Two-flop synchroniser followed by a minimum-width filter.
  Assumes d may change at any time relative to aclk.
*/
`timescale 1ns/10ps
`default_nettype none

module rsc_qual #(
  parameter logic [7:0] N = 8'h01
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Level in and qualified level out
  input wire logic d,
  output logic q
);

  rsc_pkg::rsc_qual_s s, next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    if (!s.s2) begin
      next_s.cnt = 8'h00;
      next_s.q = 1'b0;
    end else begin
      if (s.cnt != 8'hff) begin
        next_s.cnt = s.cnt + 8'h01;
      end
      next_s.q = (s.cnt >= N - 8'h01);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule

`default_nettype wire

// [rtl/rsc_delay.sv]
/*
  Start-up delay counter. Counts ticks of a 1 us divider once hold drops.
  Assumes ticks is steady while hold is low.
*/
`timescale 1ns/10ps
`default_nettype none

`include "rsc_consts.svh"

module rsc_delay (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  rsc_dly_if.cnt dly
);

  rsc_pkg::rsc_dly_s s, next_s;
  logic tick;

  assign tick = (s.div == 7'(`RSC_TICK_CYC - 1));

  always_comb begin
    next_s = s;
    next_s.div = tick ? 7'h00 : s.div + 7'h01;
    case (s.st)
      rsc_pkg::RSC_HOLD: begin
        next_s.div = 7'h00;
        next_s.cnt = 17'h00000;
        if (!dly.hold) begin
          next_s.st = (dly.ticks == 17'h00000) ? rsc_pkg::RSC_RUN : rsc_pkg::RSC_COUNT;
        end
      end
      rsc_pkg::RSC_COUNT: begin
        if (dly.hold) begin
          next_s.st = rsc_pkg::RSC_HOLD;
        end else if (tick) begin
          next_s.cnt = s.cnt + 17'h00001;
          if (s.cnt + 17'h00001 == dly.ticks) begin
            next_s.st = rsc_pkg::RSC_RUN;
          end
        end
      end
      rsc_pkg::RSC_RUN: begin
        if (dly.hold) begin
          next_s.st = rsc_pkg::RSC_HOLD;
        end
      end
      default: begin
        next_s.st = rsc_pkg::RSC_HOLD;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dly.busy = (s.st != rsc_pkg::RSC_RUN);

endmodule

`default_nettype wire

// [rtl/rsc_top.sv]
/*
  System reset controller: combines the reset sources into one internal
  reset, stretched by a fuse-selected start-up delay, with cause flags,
  interrupt and an AXI4-Lite register slave.
  Assumes watchdog, USB and fuse inputs come from logic on aclk; supply,
  undervolt, reset pin and JTAG bit are asynchronous.
*/
//
// Operation
// - Reset loads I/O registers to initial values; fetch starts at reset vector after.
// - I/O ports reset at once, without a clock, on supply-low, pin low or enabled undervolt; other sources reach them through the registered cpu_rst.
// - After all sources drop, hold reset for the fuse-selected delay count.
// - Supply-low asserts reset at once; release goes through the delay counter.
// - Pin low beyond minimum width resets even clockless; shorter pulses may not.
// - Pin returning high starts the delay; run resumes after the time-out.
// - Undervolt level code 111 disables detection; lower codes pick higher levels.
// - Enabled undervolt resets at once; release goes through the delay counter.
// - Undervolt reset only when the low supply outlasts the filter time; I/O ports still reset on any enabled undervolt pulse, unfiltered.
// - Watchdog time-out resets only when enabled, as a one-cycle pulse.
// - Delay counting starts on the falling edge of the watchdog pulse.
// - Processor stays reset while the JTAG reset chain bit is one.
// - Enabled USB end-of-reset resets the processor, USB controller stays up.
// - Each source sets its flag; writing zero clears; power-on keeps only its own.
`timescale 1ns/10ps
`default_nettype none

`include "rsc_consts.svh"

module rsc_top #(
  parameter logic [16:0] TOUT_MID_TICKS = 17'(`RSC_TOUT_MID_US / `RSC_TICK_US),
  parameter logic [16:0] TOUT_LONG_TICKS = 17'(`RSC_TOUT_LONG_US / `RSC_TICK_US)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Reset sources
  input wire logic supply_low,
  input wire logic reset_pin_n,
  input wire logic undervolt_detector,
  input wire logic wdt_timeout,
  input wire logic wdt_enable,
  input wire logic jtag_reset_bit,
  input wire logic usb_end_of_reset,
  // Fuses
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_source_fuses,
  input wire logic [2:0] undervolt_level_fuses,
  // Reset outputs
  output logic io_reset_n,
  output logic cpu_reset_n,
  output logic usb_ctrl_reset_n,
  output logic cpu_fetch_start,
  output logic undervolt_enable,
  output logic [2:0] undervolt_trip_level,
  // Interrupt
  output logic irq
);

  rsc_pkg::rsc_top_s s, next_s;
  rsc_dly_if dly ();

  logic por_lvl, ext_lvl, bod_raw, bod_lvl, jtag_lvl, uv_en;
  logic [5:0] ev;
  logic wr_go, rd_go;
  logic [16:0] base_ticks, extra_ticks;

  rsc_qual #(.N(8'h01)) u_por (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(supply_low),
    .q(por_lvl)
  );

  // pin low must outlast the minimum width
  rsc_qual #(.N(8'(`RSC_RST_CYC))) u_ext (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(~reset_pin_n),
    .q(ext_lvl)
  );

  rsc_qual #(.N(8'(`RSC_BOD_CYC))) u_bod (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(undervolt_detector),
    .q(bod_raw)
  );

  rsc_qual #(.N(8'h01)) u_jtag (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(jtag_reset_bit),
    .q(jtag_lvl)
  );

  rsc_delay u_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .dly(dly)
  );

  assign uv_en = (undervolt_level_fuses != `RSC_UV_OFF);
  assign undervolt_enable = uv_en;
  assign undervolt_trip_level = undervolt_level_fuses;
  assign bod_lvl = bod_raw & uv_en;

  assign base_ticks = (startup_time_fuses == 2'h0) ? 17'(`RSC_TOUT_SHORT_US / `RSC_TICK_US) :
                      (startup_time_fuses == 2'h1) ? TOUT_MID_TICKS : TOUT_LONG_TICKS;
  // Crystal selections need extra oscillator settling
  assign extra_ticks = clock_source_fuses[3] ? 17'(`RSC_XTAL_START_US / `RSC_TICK_US) : 17'h00000;
  assign dly.ticks = base_ticks + extra_ticks;

  // JTAG bit holds reset as a level
  assign dly.hold = por_lvl | ext_lvl | bod_lvl | jtag_lvl | s.wdt_pulse | s.usb_pulse;

  assign ev[`RSC_B_POR] = por_lvl & ~s.por_q;
  assign ev[`RSC_B_EXT] = ext_lvl & ~s.ext_q;
  assign ev[`RSC_B_BOD] = bod_lvl & ~s.bod_q;
  assign ev[`RSC_B_WDT] = s.wdt_pulse;
  assign ev[`RSC_B_JTAG] = jtag_lvl & ~s.jtag_q;
  assign ev[`RSC_B_USB] = s.usb_pulse;

  // Write address and data are taken together
  assign awready = awvalid & wvalid & ~s.bvalid;
  assign wready = awready;
  assign wr_go = awready;
  assign arready = ~s.rvalid;
  assign rd_go = arvalid & ~s.rvalid;

  always_comb begin
    next_s = s;
    next_s.por_q = por_lvl;
    next_s.ext_q = ext_lvl;
    next_s.bod_q = bod_lvl;
    next_s.jtag_q = jtag_lvl;
    next_s.wdt_pulse = wdt_timeout & wdt_enable & ~s.wdt_pulse;
    next_s.usb_pulse = usb_end_of_reset & s.usb_cpu_en & ~s.usb_pulse;
    next_s.cpu_rst = dly.busy;
    // fetch from reset vector on release
    next_s.fetch = s.cpu_rst & ~dly.busy;

    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end

    if (wr_go) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = `RSC_RESP_OK;
      if (awaddr == `RSC_OFF_CAUSE) begin
        if (wstrb[0]) begin
          next_s.cause = s.cause & wdata[5:0];
        end
      end else if (awaddr == `RSC_OFF_IRQ_ST) begin
        if (wstrb[0]) begin
          next_s.irq_st = s.irq_st & ~wdata[5:0];
        end
      end else if (awaddr == `RSC_OFF_IRQ_MASK) begin
        if (wstrb[0]) begin
          next_s.irq_mask = wdata[5:0];
        end
      end else if (awaddr == `RSC_OFF_CTRL) begin
        if (wstrb[0]) begin
          next_s.usb_cpu_en = wdata[`RSC_B_USB_CPU_EN];
        end
      end else if (awaddr == `RSC_OFF_STATE) begin
        next_s.bresp = `RSC_RESP_OK;
      end else begin
        next_s.bresp = `RSC_RESP_ERR;
      end
    end

    // set wins over clear; power-on keeps only its own flag
    if (ev[`RSC_B_POR]) begin
      next_s.cause = 6'h01 << `RSC_B_POR;
    end else begin
      next_s.cause = next_s.cause | ev;
    end
    next_s.irq_st = next_s.irq_st | ev;

    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `RSC_RESP_OK;
      next_s.rdata = 32'h00000000;
      if (araddr == `RSC_OFF_CAUSE) begin
        next_s.rdata[5:0] = s.cause;
      end else if (araddr == `RSC_OFF_IRQ_ST) begin
        next_s.rdata[5:0] = s.irq_st;
      end else if (araddr == `RSC_OFF_IRQ_MASK) begin
        next_s.rdata[5:0] = s.irq_mask;
      end else if (araddr == `RSC_OFF_CTRL) begin
        next_s.rdata[`RSC_B_USB_CPU_EN] = s.usb_cpu_en;
      end else if (araddr == `RSC_OFF_STATE) begin
        next_s.rdata[`RSC_B_BUSY] = dly.busy;
        next_s.rdata[`RSC_B_BOD_EN] = uv_en;
        next_s.rdata[`RSC_F_SUT_LSB +: 2] = startup_time_fuses;
        next_s.rdata[`RSC_F_CLOCK_SOURCE_FUSES_LSB +: 4] = clock_source_fuses;
      end else begin
        next_s.rresp = `RSC_RESP_ERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.cpu_rst <= 1'b1;
      s.cause <= `RSC_CAUSE_RST;
      s.irq_mask <= `RSC_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // asynchronous port reset path, no clock needed
  assign io_reset_n = ~(supply_low | ~reset_pin_n | (undervolt_detector & uv_en) | s.cpu_rst);
  assign cpu_reset_n = ~s.cpu_rst;
  // USB end-of-reset is left out so the controller stays attached
  assign usb_ctrl_reset_n = ~(por_lvl | ext_lvl | bod_lvl | jtag_lvl | s.wdt_pulse);
  assign cpu_fetch_start = s.fetch;
  assign irq = |(s.irq_st & s.irq_mask);
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;

endmodule

`default_nettype wire

// [dv/rsc_assertions.sv]
/*
  Port checker of rsc_top, bound to every instance.
  Assumes the short time-out parameters and one aclk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module rsc_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Sources and fuses
  input wire logic supply_low,
  input wire logic reset_pin_n,
  input wire logic wdt_timeout,
  input wire logic wdt_enable,
  input wire logic jtag_reset_bit,
  input wire logic [2:0] undervolt_level_fuses,
  // Reset outputs
  input wire logic io_reset_n,
  input wire logic cpu_reset_n,
  input wire logic cpu_fetch_start,
  input wire logic undervolt_enable,
  input wire logic [2:0] undervolt_trip_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_io_async_path: assert property ((supply_low || !reset_pin_n) |-> !io_reset_n)
    else $error("io reset missing while a source is active");
  chk_supply_holds_cpu: assert property (supply_low [*8] |-> !cpu_reset_n)
    else $error("cpu runs during low supply");
  chk_jtag_holds_cpu: assert property (jtag_reset_bit [*8] |-> !cpu_reset_n)
    else $error("cpu runs while jtag bit is one");
  chk_undervolt_fuse_code: assert property (undervolt_trip_level == undervolt_level_fuses
    && undervolt_enable == (undervolt_level_fuses != 3'h7))
    else $error("undervolt enable or level wrong");
  chk_wdt_resets_cpu: assert property ($rose(wdt_timeout) && wdt_enable
    |-> ##[1:3] !cpu_reset_n)
    else $error("watchdog time-out gave no reset");
  chk_fetch_on_release: assert property (cpu_fetch_start == $rose(cpu_reset_n))
    else $error("fetch start not on release");
  chk_release_after_drop: assert property ($rose(cpu_reset_n) |-> !$past(supply_low, 4)
    && !$past(jtag_reset_bit, 4) && $past(reset_pin_n, 4))
    else $error("release while a source was active");
  chk_write_answered: assert property (awvalid && awready |=> bvalid)
    else $error("no write response");
  chk_read_answered: assert property (arvalid && arready |=> rvalid)
    else $error("no read response");
endmodule

bind rsc_top rsc_assertions rsc_assertions_i (.aclk, .aresetn, .awvalid, .awready, .bvalid,
  .arvalid, .arready, .rvalid, .supply_low, .reset_pin_n, .wdt_timeout, .wdt_enable,
  .jtag_reset_bit, .undervolt_level_fuses, .io_reset_n, .cpu_reset_n, .cpu_fetch_start,
  .undervolt_enable, .undervolt_trip_level);

`default_nettype wire

// [dv/rsc_src_model.sv]
/*
  Far side of the reset controller: supply monitor, reset pin,
  undervolt detector, watchdog, JTAG chain bit and USB detector.
  Assumes callers enter hit just after a rising aclk edge.
*/
`timescale 1ns/10ps
`default_nettype none

module rsc_src_model (
  // Clock
  input wire logic aclk,
  // Source levels
  output logic supply_low,
  output logic reset_pin_n,
  output logic undervolt_detector,
  output logic wdt_timeout,
  output logic jtag_reset_bit,
  output logic usb_end_of_reset
);
  initial begin
    supply_low = 1'b0;
    reset_pin_n = 1'b1;
    undervolt_detector = 1'b0;
    wdt_timeout = 1'b0;
    jtag_reset_bit = 1'b0;
    usb_end_of_reset = 1'b0;
  end

  // One source active for len cycles; all sources idle afterwards
  task automatic hit(input int idx, input int len);
    case (idx)
      0: supply_low <= 1'b1;
      1: reset_pin_n <= 1'b0;
      2: undervolt_detector <= 1'b1;
      3: wdt_timeout <= 1'b1;
      4: jtag_reset_bit <= 1'b1;
      default: usb_end_of_reset <= 1'b1;
    endcase
    repeat (len) @(posedge aclk);
    supply_low <= 1'b0;
    reset_pin_n <= 1'b1;
    undervolt_detector <= 1'b0;
    wdt_timeout <= 1'b0;
    jtag_reset_bit <= 1'b0;
    usb_end_of_reset <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [dv/rsc_top_test.sv]
/*
  Self-checking bench of rsc_top with an AXI4-Lite master and the
  source model. Assumes a mid time-out of 4 ticks of 125 cycles.
*/
`timescale 1ns/10ps
`default_nettype none

`include "rsc_consts.svh"

module rsc_top_test;
  localparam int DLY = 4 * 125;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, wdt_enable = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, clock_source_fuses = 4'h0;
  logic [1:0] startup_time_fuses = 2'h1, bresp, rresp;
  logic [2:0] undervolt_level_fuses = 3'h6, undervolt_trip_level;
  logic awready, wready, bvalid, arready, rvalid, supply_low, reset_pin_n;
  logic undervolt_detector, wdt_timeout, jtag_reset_bit, usb_end_of_reset;
  logic io_reset_n, cpu_reset_n, usb_ctrl_reset_n, cpu_fetch_start, undervolt_enable, irq;
  logic saw_low = 1'b0, saw_usb = 1'b0;
  int num_errors = 0, check_count = 0, cyc = 0;

  rsc_src_model rsc_src_model_i (.aclk, .supply_low, .reset_pin_n, .undervolt_detector,
    .wdt_timeout, .jtag_reset_bit, .usb_end_of_reset);
  rsc_top #(.TOUT_MID_TICKS(17'h4), .TOUT_LONG_TICKS(17'h8)) rsc_top_i (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .supply_low,
    .reset_pin_n, .undervolt_detector, .wdt_timeout, .wdt_enable, .jtag_reset_bit,
    .usb_end_of_reset, .startup_time_fuses, .clock_source_fuses, .undervolt_level_fuses,
    .io_reset_n, .cpu_reset_n, .usb_ctrl_reset_n, .cpu_fetch_start, .undervolt_enable,
    .undervolt_trip_level, .irq);

  initial forever #4 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (!cpu_reset_n) saw_low <= 1'b1;
    if (!usb_ctrl_reset_n) saw_usb <= 1'b1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Pulse a source, then time the release from its drop
  task automatic event_run(input int idx, input int len, input logic exp);
    int n;
    n = 0;
    saw_low <= 1'b0;
    saw_usb <= 1'b0;
    @(posedge aclk);
    rsc_src_model_i.hit(idx, len);
    repeat (4) @(posedge aclk);
    while (cpu_reset_n !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    chk_bit(saw_low, exp);
    if (exp) chk_bit(n > DLY - 10 && n < DLY + 40, 1'b1);
  endtask

  task automatic cause_is(input logic [5:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(`RSC_OFF_CAUSE, d, r);
    chk(d, {26'h0, e});
    wr(`RSC_OFF_CAUSE, 32'h0);
    wr(`RSC_OFF_IRQ_ST, 32'h3f);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(`RSC_OFF_IRQ_MASK, d, r);
    chk(d, 32'h0);
    rd(`RSC_OFF_CTRL, d, r);
    chk(d, 32'h0);
    rd(8'h20, d, r);
    chk({30'h0, r}, {30'h0, `RSC_RESP_ERR});
    // fuse 110 enables undervolt; idle, mid start-up, no crystal
    rd(`RSC_OFF_STATE, d, r);
    chk(d, 32'h00000012);
    cause_is(6'h00);
  endtask

  task automatic t_pin_uv();
    event_run(1, 20, 1'b0);
    event_run(1, 60, 1'b1);
    cause_is(6'h02);
    event_run(2, 50, 1'b0);
    event_run(2, 200, 1'b1);
    cause_is(6'h04);
    undervolt_level_fuses <= 3'h7;
    event_run(2, 200, 1'b0);
    undervolt_level_fuses <= 3'h6;
  endtask

  task automatic t_wdt_irq();
    event_run(3, 1, 1'b0);
    wdt_enable <= 1'b1;
    event_run(3, 1, 1'b1);
    chk_bit(irq, 1'b0);
    wr(`RSC_OFF_IRQ_MASK, 32'h8);
    chk_bit(irq, 1'b1);
    wr(`RSC_OFF_IRQ_ST, 32'h8);
    chk_bit(irq, 1'b0);
    wr(`RSC_OFF_IRQ_MASK, 32'h0);
    cause_is(6'h08);
  endtask

  task automatic t_jtag_usb();
    event_run(4, 1000, 1'b1);
    cause_is(6'h10);
    event_run(5, 1, 1'b0);
    wr(`RSC_OFF_CTRL, 32'h1);
    event_run(5, 1, 1'b1);
    chk_bit(saw_usb, 1'b0);
    cause_is(6'h20);
  endtask

  // Second source during the count; power-on keeps only its own flag
  task automatic t_restart();
    rsc_src_model_i.hit(1, 60);
    repeat (200) @(posedge aclk);
    event_run(0, 10, 1'b1);
    cause_is(6'h01);
  endtask

  // Long start-up selection stretches release to 8 ticks
  task automatic t_fuses();
    int n;
    n = 0;
    startup_time_fuses <= 2'h2;
    saw_low <= 1'b0;
    @(posedge aclk);
    rsc_src_model_i.hit(3, 1);
    repeat (4) @(posedge aclk);
    while (cpu_reset_n !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    chk_bit(saw_low, 1'b1);
    chk_bit(n > 8 * 125 - 10 && n < 8 * 125 + 40, 1'b1);
    startup_time_fuses <= 2'h1;
    cause_is(6'h08);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    while (cpu_reset_n !== 1'b1) @(posedge aclk);
    t_regs();
    event_run(0, 10, 1'b1);
    cause_is(6'h01);
    t_pin_uv();
    t_wdt_irq();
    t_jtag_usb();
    t_restart();
    t_fuses();
    final_report();
  end
endmodule

`default_nettype wire
